// file: common/hcrw_pkg.sv
package hcrw_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Clock rates and timing
	localparam int unsigned OSC_HZ       = 15360000;
	localparam int unsigned SLOW_HZ      = 32000;
	localparam int unsigned SLOW_DIV     = OSC_HZ / SLOW_HZ;
	localparam int unsigned T_R_MS       = 56;
	localparam int unsigned T_R_TICKS    = T_R_MS * SLOW_HZ / 1000;
	localparam int unsigned BP_RUN_US    = 1375;
	localparam int unsigned BP_RUN_TICKS = BP_RUN_US * SLOW_HZ / 1000000;

	////////////////////////////////////////////////////////////////////////////////
	// Processor clock prescaler codes
	localparam logic [1:0] PRE_DIV1  = 2'h0;
	localparam logic [1:0] PRE_DIV2  = 2'h1;
	localparam logic [1:0] PRE_DIV4  = 2'h2;
	localparam logic [1:0] PRE_DIV8  = 2'h3;
	localparam logic [1:0] PRE_RESET = PRE_DIV2;

	////////////////////////////////////////////////////////////////////////////////
	// Watchdog toggle patterns {watchdog_toggle_a, watchdog_toggle_b}
	localparam logic [1:0] WD_PAT_ARM   = 2'h2;
	localparam logic [1:0] WD_PAT_FIRST = 2'h1;

	////////////////////////////////////////////////////////////////////////////////
	// Command/indicate codes (arbitrary values)
	localparam int unsigned CI_W        = 4;
	localparam logic [3:0]  CI_RESET_IND = 4'h0;
	localparam logic [3:0]  CI_DEACT_IND = 4'hf;

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchroniser slots and their idle levels
	localparam int unsigned PIN_CS  = 0;
	localparam int unsigned PIN_UP  = 1;
	localparam int unsigned PIN_LOW = 2;
	localparam int unsigned PIN_OSC = 3;
	localparam int unsigned PIN_EXT = 4;
	localparam int unsigned PIN_RST = 5;
	localparam int unsigned PIN_DU  = 6;
	localparam int unsigned PIN_N   = 7;
	localparam logic [6:0]  PIN_IDLE = 7'h41;

	typedef enum logic [2:0] {
		ST_HOLD   = 3'h0,
		ST_POR    = 3'h1,
		ST_RUN    = 3'h2,
		ST_WD     = 3'h3,
		ST_WD_RST = 3'h4
	} hcrw_state_e;

endpackage

// file: src/hcrw_tick_timer.sv
`timescale 1ns/10ps
module hcrw_tick_timer #(
	parameter int unsigned LEN = hcrw_pkg::T_R_TICKS
) (
	input  wire logic sys_clk, // System clock
	input  wire logic rst_n,   // Synchronous reset, active low
	input  wire logic tick,    // 32 kHz enable pulse
	input  wire logic start,   // Restart the count
	output logic      busy,    // Count in progress
	output logic      done     // Pulse when LEN ticks elapsed
);
	localparam int W = $clog2(LEN + 1);

	logic [W-1:0] cnt_q;
	logic         busy_q;
	logic         done_q;
	logic         last;

	assign last = busy_q && tick && (cnt_q == W'(LEN - 1));

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cnt_q  <= '0;
			busy_q <= 1'b0;
		end else if (start) begin
			cnt_q  <= '0;
			busy_q <= 1'b1;
		end else if (last) begin
			busy_q <= 1'b0;
		end else if (busy_q && tick) begin
			cnt_q <= cnt_q + W'(1);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			done_q <= 1'b0;
		end else begin
			done_q <= last && !start;
		end
	end

	assign busy = busy_q;
	assign done = done_q;

	AST_TIMER_TICK: assert property (@(posedge sys_clk) disable iff (!rst_n)
		busy_q && !tick && !start |=> $stable(cnt_q))
		else $error("timer advanced without a slow tick");
endmodule

// file: src/hcrw_mclk_div.sv
`timescale 1ns/10ps
module hcrw_mclk_div (
	input  wire logic       sys_clk,  // System clock
	input  wire logic       rst_n,    // Synchronous reset, active low
	input  wire logic       osc_tick, // 15.36 MHz enable pulse
	input  wire logic [1:0] sel_req,  // Requested prescaler code
	input  wire logic       apply_ok, // Chip select idle
	input  wire logic       stop,     // Force clock low
	output logic            mclk,     // Processor clock
	output logic [1:0]      sel_cur   // Code in use
);
	logic [3:0] cnt_q;
	logic [3:0] cnt_d;
	logic [1:0] sel_q;
	logic [1:0] sel_d;
	logic       mclk_q;
	logic       wrap;

	assign wrap  = osc_tick && (cnt_q == 4'hf);
	assign cnt_d = osc_tick ? cnt_q + 4'h1 : cnt_q;
	assign sel_d = (wrap && apply_ok) ? sel_req : sel_q;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cnt_q <= 4'h0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			sel_q <= hcrw_pkg::PRE_RESET;
		end else begin
			sel_q <= sel_d;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			mclk_q <= 1'b0;
		end else begin
			mclk_q <= !stop && cnt_d[sel_d];
		end
	end

	assign mclk    = mclk_q;
	assign sel_cur = sel_q;

	AST_SEL_ALIGN: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$changed(sel_q) |-> cnt_q == 4'h0 && !mclk_q)
		else $error("prescaler changed off the slow boundary");

	AST_SEL_CS: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$changed(sel_q) |-> $past(apply_ok))
		else $error("prescaler changed while chip select active");
endmodule

// file: src/hcrw_top.sv
`timescale 1ns/10ps
// What this block does
// - Processor clock at 7.68/3.84/1.92/0.96 MHz.
// - Rate changes glitch free at slowest boundary.
// - Reset selects 3.84 MHz.
// - New rate applies after chip select idle.
// - Open-drain interrupt, masked during chip select.
// - Request cleared by status byte one reads or internal reset pulse.
// - Unread request reasserts once chip select rises.
// - Complementary resets, or external reset input mode.
// - Wait upper threshold, then 1792 slow ticks.
// - Reset reasserts when supply drops below lower.
// - Outside external reset mode, undervoltage stops processor clock low immediately.
// - Power-up reset extended until oscillator stable.
// - Counter off after delay; pattern 10 arms watchdog.
// - Missed sequence gives 56 ms reset pulse.
// - Watchdog clears strobe, width, prescaler, ring bits.
// - Undervoltage pulse clears registers, resets transceiver.
// - Backplane clocks run 11 frames, then stop.
// - Power-up bit, upstream low, activation restart clocks.
// - First status-one read sets change flag.
// - Indication copied only while backplane clocks run.
// - External mode: clocks run during reset input.
// - Prescaler divides 7.68 MHz by 1,2,4,8.
// - Reset counter runs on 32 kHz clock.
module hcrw_top #(
	parameter int unsigned SLOW_DIV = hcrw_pkg::SLOW_DIV,
	parameter int unsigned TR_TICKS = hcrw_pkg::T_R_TICKS,
	parameter int unsigned BP_TICKS = hcrw_pkg::BP_RUN_TICKS
) (
	input  wire logic       sys_clk,                // 200 MHz clock
	input  wire logic       rst_n,                  // Synchronous reset
	input  wire logic       osc_tick,               // 15.36 MHz enable
	input  wire logic       cs_n,                   // Serial chip select pin
	input  wire logic       upper_supply_threshold, // Supply above upper level
	input  wire logic       lower_supply_threshold, // Supply below lower level
	input  wire logic       osc_stable,             // Oscillator settled
	input  wire logic       ext_reset_mode,         // Strap: external reset mode
	input  wire logic       reset_pin_i,            // Reset pin level in
	output logic            reset_pin_o,            // Reset pin drive, high active
	output logic            reset_pin_oe,           // Reset pin enable
	output logic            reset_n_out,            // Inverse reset output
	input  wire logic       upstream_line,          // Upstream data line
	output logic            mclk,                   // Processor clock
	output logic            int_n_o,                // Interrupt pin level
	output logic            int_n_oe,               // Interrupt pin enable
	input  wire logic       ctrl_wr,                // Control write strobe
	input  wire logic [1:0] prescale_wdata,         // Prescale code written
	input  wire logic [2:0] strobe_wdata,           // Strobe select written
	input  wire logic [5:0] pulse_width_wdata,      // Pulse width written
	input  wire logic       ring_contrast_wdata,    // Ring/contrast written
	input  wire logic       wd_wr,                  // Toggle bits write strobe
	input  wire logic       watchdog_toggle_a,      // First toggle bit
	input  wire logic       watchdog_toggle_b,      // Second toggle bit
	input  wire logic       irq_event,              // Status event pulse
	input  wire logic       status_byte_one_read,              // Status byte one read
	input  wire logic       status_byte_two_read,              // Status byte two read
	input  wire logic [3:0] ci_in,                  // Transceiver indication
	input  wire logic       ci_in_valid,            // Indication strobe
	input  wire logic       clock_power_up_request, // Clock power-up bit
	input  wire logic       line_activation_req,    // Far-end activation
	input  wire logic       line_deactivated,       // Line interface idle
	output logic [1:0]      prescale_select,        // Prescale code register
	output logic [2:0]      strobe_select,          // Strobe select register
	output logic [5:0]      pulse_width_field,      // Pulse width register
	output logic            ring_contrast_select,   // Ring/contrast register
	output logic            xcvr_reset,             // Transceiver reset pulse
	output logic            bp_clk_run,             // Backplane clocks enable
	output logic            ci_change_flag,         // Indication change flag
	output logic [3:0]      status_ci               // Indication in status two
);
	localparam int DIV_W = $clog2(SLOW_DIV);
	localparam int BP_W  = $clog2(BP_TICKS + 1);

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [6:0] pin_raw;
	logic [6:0] s1_q;
	logic [6:0] s2_q;
	logic [6:0] s3_q;
	logic [6:0] pin_f_q;

	assign pin_raw = {upstream_line, reset_pin_i, ext_reset_mode, osc_stable,
		lower_supply_threshold, upper_supply_threshold, cs_n};

	genvar gi;
	generate
		for (gi = 0; gi < hcrw_pkg::PIN_N; gi++) begin : g_sync
			always_ff @(posedge sys_clk) begin
				if (!rst_n) begin
					s1_q[gi]    <= hcrw_pkg::PIN_IDLE[gi];
					s2_q[gi]    <= hcrw_pkg::PIN_IDLE[gi];
					s3_q[gi]    <= hcrw_pkg::PIN_IDLE[gi];
					pin_f_q[gi] <= hcrw_pkg::PIN_IDLE[gi];
				end else begin
					s1_q[gi] <= pin_raw[gi];
					s2_q[gi] <= s1_q[gi];
					s3_q[gi] <= s2_q[gi];
					if (s2_q[gi] == s3_q[gi]) begin
						pin_f_q[gi] <= s3_q[gi];
					end
				end
			end
		end
	endgenerate

	logic cs_idle;
	logic ext;
	logic uv;
	logic rst_in;

	assign cs_idle = pin_f_q[hcrw_pkg::PIN_CS];
	assign ext     = pin_f_q[hcrw_pkg::PIN_EXT];
	assign uv      = pin_f_q[hcrw_pkg::PIN_LOW] && !ext;
	assign rst_in  = pin_f_q[hcrw_pkg::PIN_RST];

	////////////////////////////////////////////////////////////////////////////////
	// 32 kHz enable and reset/watchdog counter
	logic [DIV_W-1:0] div_q;
	logic             slow_tick_q;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			div_q       <= '0;
			slow_tick_q <= 1'b0;
		end else begin
			slow_tick_q <= 1'b0;
			if (osc_tick) begin
				if (div_q == DIV_W'(SLOW_DIV - 1)) begin
					div_q       <= '0;
					slow_tick_q <= 1'b1;
				end else begin
					div_q <= div_q + DIV_W'(1);
				end
			end
		end
	end

	logic tr_start;
	logic tr_done;

	hcrw_tick_timer #(.LEN(TR_TICKS)) u_timer (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.tick    (slow_tick_q),
		.start   (tr_start),
		.busy    (),
		.done    (tr_done)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Reset and watchdog sequencer
	hcrw_pkg::hcrw_state_e state_q;
	hcrw_pkg::hcrw_state_e state_d;
	logic                  wd_phase_q;
	logic                  wd_phase_d;
	logic                  int_rst_d;
	logic                  int_rst_q;
	logic                  wd_clr_d;
	logic                  wd_clr_q;
	logic [1:0]            wd_pat;

	assign wd_pat = {watchdog_toggle_a, watchdog_toggle_b};

	always_comb begin
		state_d    = state_q;
		wd_phase_d = wd_phase_q;
		tr_start   = 1'b0;
		int_rst_d  = 1'b0;
		wd_clr_d   = 1'b0;
		if (uv) begin
			state_d = hcrw_pkg::ST_HOLD;
		end else begin
			unique case (state_q)
				hcrw_pkg::ST_HOLD: begin
					if (ext) begin
						state_d = hcrw_pkg::ST_RUN;
					end else if (pin_f_q[hcrw_pkg::PIN_UP] && pin_f_q[hcrw_pkg::PIN_OSC]) begin
						state_d   = hcrw_pkg::ST_POR;
						tr_start  = 1'b1;
						int_rst_d = 1'b1;
					end
				end
				hcrw_pkg::ST_POR: begin
					if (tr_done) begin
						state_d = hcrw_pkg::ST_RUN;
					end
				end
				hcrw_pkg::ST_RUN: begin
					if (wd_wr && wd_pat == hcrw_pkg::WD_PAT_ARM) begin
						state_d    = hcrw_pkg::ST_WD;
						tr_start   = 1'b1;
						wd_phase_d = 1'b0;
					end
				end
				hcrw_pkg::ST_WD: begin
					if (tr_done) begin
						state_d  = hcrw_pkg::ST_WD_RST;
						tr_start = 1'b1;
						wd_clr_d = 1'b1;
					end else if (wd_wr && wd_pat == hcrw_pkg::WD_PAT_FIRST) begin
						wd_phase_d = 1'b1;
					end else if (wd_wr && wd_pat == hcrw_pkg::WD_PAT_ARM && wd_phase_q) begin
						tr_start   = 1'b1;
						wd_phase_d = 1'b0;
					end
				end
				hcrw_pkg::ST_WD_RST: begin
					if (tr_done) begin
						state_d = hcrw_pkg::ST_RUN;
					end
				end
				default: begin
					state_d = hcrw_pkg::ST_HOLD;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_q    <= hcrw_pkg::ST_HOLD;
			wd_phase_q <= 1'b0;
			int_rst_q  <= 1'b0;
			wd_clr_q   <= 1'b0;
		end else begin
			state_q    <= state_d;
			wd_phase_q <= wd_phase_d;
			int_rst_q  <= int_rst_d;
			wd_clr_q   <= wd_clr_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Reset pins and transceiver reset
	logic rst_act_q;
	logic rst_n_out_q;
	logic rst_oe_q;
	logic rst_in_d1_q;
	logic xcvr_rst_q;
	logic rst_act;

	assign rst_act = (state_q != hcrw_pkg::ST_RUN) && (state_q != hcrw_pkg::ST_WD);

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rst_act_q   <= 1'b1;
			rst_n_out_q <= 1'b0;
			rst_oe_q    <= 1'b1;
		end else begin
			rst_act_q   <= rst_act;
			rst_n_out_q <= ext ? !rst_in : !rst_act;
			rst_oe_q    <= !ext;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rst_in_d1_q <= 1'b0;
			xcvr_rst_q  <= 1'b0;
		end else begin
			rst_in_d1_q <= rst_in;
			xcvr_rst_q  <= int_rst_q || (ext && rst_in_d1_q && !rst_in);
		end
	end

	assign reset_pin_o  = rst_act_q;
	assign reset_pin_oe = rst_oe_q;
	assign reset_n_out  = rst_n_out_q;
	assign xcvr_reset   = xcvr_rst_q;

	////////////////////////////////////////////////////////////////////////////////
	// Control registers and processor clock
	logic [1:0] pre_q;
	logic [2:0] sds_q;
	logic [5:0] pw_q;
	logic       ring_q;

	always_ff @(posedge sys_clk) begin
		if (!rst_n || int_rst_q) begin
			pre_q  <= hcrw_pkg::PRE_RESET;
			sds_q  <= 3'h0;
			pw_q   <= 6'h00;
			ring_q <= 1'b0;
		end else if (wd_clr_q) begin
			pre_q  <= hcrw_pkg::PRE_RESET;
			sds_q  <= 3'h0;
			pw_q   <= 6'h00;
			ring_q <= 1'b0;
		end else if (ctrl_wr) begin
			pre_q  <= prescale_wdata;
			sds_q  <= strobe_wdata;
			pw_q   <= pulse_width_wdata;
			ring_q <= ring_contrast_wdata;
		end
	end

	assign prescale_select      = pre_q;
	assign strobe_select        = sds_q;
	assign pulse_width_field    = pw_q;
	assign ring_contrast_select = ring_q;

	hcrw_mclk_div u_mclk (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.osc_tick (osc_tick),
		.sel_req  (pre_q),
		.apply_ok (cs_idle),
		.stop     (uv),
		.mclk     (mclk),
		.sel_cur  ()
	);

	////////////////////////////////////////////////////////////////////////////////
	// Backplane clocks
	logic [BP_W-1:0] bp_cnt_q;
	logic            bp_win_q;
	logic            bp_run_q;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			bp_cnt_q <= '0;
			bp_win_q <= 1'b0;
		end else if (int_rst_q) begin
			bp_cnt_q <= '0;
			bp_win_q <= 1'b1;
		end else if (bp_win_q && slow_tick_q) begin
			if (bp_cnt_q == BP_W'(BP_TICKS - 1)) begin
				bp_win_q <= 1'b0;
			end else begin
				bp_cnt_q <= bp_cnt_q + BP_W'(1);
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			bp_run_q <= 1'b0;
		end else begin
			bp_run_q <= bp_win_q || (ext && rst_in) || clock_power_up_request ||
				!pin_f_q[hcrw_pkg::PIN_DU] || line_activation_req || !line_deactivated;
		end
	end

	assign bp_clk_run = bp_run_q;

	////////////////////////////////////////////////////////////////////////////////
	// Indication buffer, change flag and interrupt
	logic [3:0] ci_buf_q;
	logic [3:0] sta_ci_q;
	logic       cic_arm_q;
	logic       cic_q;
	logic       gen_q;
	logic       int_oe_q;
	logic       cic_set;

	always_ff @(posedge sys_clk) begin
		if (!rst_n || xcvr_rst_q) begin
			ci_buf_q <= hcrw_pkg::CI_DEACT_IND;
		end else if (ci_in_valid) begin
			ci_buf_q <= ci_in;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			sta_ci_q <= hcrw_pkg::CI_DEACT_IND;
		end else if (xcvr_rst_q) begin
			sta_ci_q <= hcrw_pkg::CI_RESET_IND;
		end else if (bp_run_q) begin
			sta_ci_q <= ci_buf_q;
		end
	end

	assign cic_set = (status_byte_one_read && cic_arm_q) || (bp_run_q && ci_buf_q != sta_ci_q);

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cic_arm_q <= 1'b0;
			cic_q     <= 1'b0;
			gen_q     <= 1'b0;
		end else begin
			if (xcvr_rst_q) begin
				cic_arm_q <= 1'b1;
			end else if (status_byte_one_read) begin
				cic_arm_q <= 1'b0;
			end
			if (cic_set) begin
				cic_q <= 1'b1;
			end else if (status_byte_two_read) begin
				cic_q <= 1'b0;
			end
			if (irq_event) begin
				gen_q <= 1'b1;
			end else if (status_byte_one_read || int_rst_q) begin
				gen_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			int_oe_q <= 1'b0;
		end else begin
			int_oe_q <= (gen_q || cic_q) && cs_idle;
		end
	end

	assign int_n_o        = 1'b0;
	assign int_n_oe       = int_oe_q;
	assign ci_change_flag = cic_q;
	assign status_ci      = sta_ci_q;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	AST_RATE_RESET: assert property ($rose(rst_n) |-> pre_q == 2'h1)
		else $error("prescale not 01 after reset");
	AST_INT_MASK: assert property (!cs_idle |=> !int_n_oe)
		else $error("interrupt driven during chip select");
	AST_INT_KEEP: assert property (gen_q && !status_byte_one_read && !int_rst_q |=> gen_q)
		else $error("request lost without status read");
	AST_INT_BACK: assert property (gen_q && cs_idle |=> int_n_oe)
		else $error("interrupt not reasserted");
	AST_UV_RESET: assert property (uv |=> !mclk ##1 reset_pin_o)
		else $error("undervoltage not reset or clock running");
	AST_WD_FIRE: assert property (state_q == hcrw_pkg::ST_WD && tr_done && !uv
		|=> state_q == hcrw_pkg::ST_WD_RST ##1 reset_pin_o)
		else $error("watchdog timeout missed");
	AST_WD_CLEAR: assert property (wd_clr_q && !int_rst_q |=>
		sds_q == 3'h0 && pw_q == 6'h00 && !ring_q)
		else $error("watchdog clear incomplete");
	AST_XCVR: assert property (int_rst_q |=> xcvr_reset ##1 !xcvr_reset)
		else $error("transceiver reset not after internal pulse");
	AST_BP_HOLD: assert property (bp_win_q |=> bp_clk_run)
		else $error("backplane clocks stopped in window");

	COV_WD_RST: cover property (state_q == hcrw_pkg::ST_WD ##1 state_q == hcrw_pkg::ST_WD_RST);
	COV_CIC: cover property (status_byte_one_read && cic_arm_q ##1 cic_q);
	COV_POR: cover property (state_q == hcrw_pkg::ST_POR ##1 state_q == hcrw_pkg::ST_RUN);
endmodule

// file: testbench/hcrw_host.sv
`timescale 1ns/10ps
module hcrw_host (
	input  wire logic sys_clk,             // System clock
	output logic       cs_n,                // Chip select
	output logic       ctrl_wr,             // Control write
	output logic [1:0] prescale_wdata,      // Prescale code
	output logic [2:0] strobe_wdata,        // Strobe select
	output logic [5:0] pulse_width_wdata,   // Pulse width
	output logic       ring_contrast_wdata, // Ring bit
	output logic       wd_wr,               // Toggle write
	output logic       watchdog_toggle_a,   // Toggle bit a
	output logic       watchdog_toggle_b,   // Toggle bit b
	output logic       status_byte_one_read,           // Status one read
	output logic       status_byte_two_read            // Status two read
);
	initial begin
		cs_n = 1'b1;
		{ctrl_wr, wd_wr, status_byte_one_read, status_byte_two_read} = 4'h0;
		{prescale_wdata, strobe_wdata, pulse_width_wdata, ring_contrast_wdata} = 12'h0;
		{watchdog_toggle_a, watchdog_toggle_b} = 2'h0;
	end

	// Waits out the pin filter
	task acc(input logic on);
		@(posedge sys_clk);
		cs_n <= ~on;
		repeat (6) @(posedge sys_clk);
	endtask

	// Idle data shows the inverse of the last value
	task wr_ctrl(input logic [11:0] v);
		@(posedge sys_clk);
		ctrl_wr <= 1'b1;
		{prescale_wdata, strobe_wdata, pulse_width_wdata, ring_contrast_wdata} <= v;
		@(posedge sys_clk);
		ctrl_wr <= 1'b0;
		{prescale_wdata, strobe_wdata, pulse_width_wdata, ring_contrast_wdata} <= ~v;
	endtask

	task wr_wd(input logic [1:0] p);
		@(posedge sys_clk);
		wd_wr <= 1'b1;
		{watchdog_toggle_a, watchdog_toggle_b} <= p;
		@(posedge sys_clk);
		wd_wr <= 1'b0;
		{watchdog_toggle_a, watchdog_toggle_b} <= ~p;
	endtask

	task rd(input logic [1:0] s);
		@(posedge sys_clk);
		{status_byte_one_read, status_byte_two_read} <= s;
		@(posedge sys_clk);
		{status_byte_one_read, status_byte_two_read} <= 2'h0;
	endtask

	task wd_service();
		wr_wd(2'h1);
		repeat (8) @(posedge sys_clk);
		wr_wd(2'h2);
	endtask
endmodule

// file: testbench/testbench.sv
`timescale 1ns/10ps
module testbench;
	logic       sys_clk, rst_n, osc_tick, cs_n, ctrl_wr, ring_contrast_wdata, wd_wr;
	logic       watchdog_toggle_a, watchdog_toggle_b, status_byte_one_read, status_byte_two_read, irq_event;
	logic       upper_supply_threshold, lower_supply_threshold, osc_stable, upstream_line;
	logic       clock_power_up_request, line_deactivated, reset_pin_o, reset_pin_oe;
	logic       reset_n_out, mclk, int_n_o, int_n_oe, xcvr_reset, bp_clk_run, ci_change_flag;
	logic       ring_contrast_select, line_activation_req, ci_in_valid;
	logic [1:0] prescale_wdata, prescale_select, prev;
	logic [2:0] strobe_wdata, strobe_select;
	logic [5:0] pulse_width_wdata, pulse_width_field;
	logic [3:0] status_ci, ci_in;
	logic [1:0] codes [4] = '{2'h0, 2'h3, 2'h2, 2'h1};
	int         n_fail = 0;
	int         checks = 0;
	int         n, t;

	hcrw_top #(.SLOW_DIV(4), .TR_TICKS(8), .BP_TICKS(3)) hcrw_top_inst (
		.sys_clk, .rst_n, .osc_tick, .cs_n, .upper_supply_threshold, .lower_supply_threshold,
		.osc_stable, .ext_reset_mode(1'b0), .reset_pin_i(1'b0), .reset_pin_o, .reset_pin_oe,
		.reset_n_out, .upstream_line, .mclk, .int_n_o, .int_n_oe, .ctrl_wr, .prescale_wdata,
		.strobe_wdata, .pulse_width_wdata, .ring_contrast_wdata, .wd_wr, .watchdog_toggle_a,
		.watchdog_toggle_b, .irq_event, .status_byte_one_read, .status_byte_two_read, .ci_in, .ci_in_valid,
		.clock_power_up_request, .line_activation_req, .line_deactivated, .prescale_select,
		.strobe_select, .pulse_width_field, .ring_contrast_select, .xcvr_reset, .bp_clk_run,
		.ci_change_flag, .status_ci
	);
	hcrw_host hcrw_host_inst (
		.sys_clk, .cs_n, .ctrl_wr, .prescale_wdata, .strobe_wdata, .pulse_width_wdata,
		.ring_contrast_wdata, .wd_wr, .watchdog_toggle_a, .watchdog_toggle_b, .status_byte_one_read, .status_byte_two_read
	);

	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) osc_tick <= ~osc_tick;

	task chk(input logic [11:0] got, input logic [11:0] exp, input string m);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task chk_n(input int got, input int lo, input int hi, input string m);
		checks++;
		if (got < lo || got > hi) begin
			n_fail++;
			$display("CHECK FAILED t=%0t %s count %0d", $time, m, got);
		end
	endtask

	task automatic wait_for(ref logic s, input logic v, output int k);
		k = 0;
		while (s !== v && k < 400) begin
			@(negedge sys_clk);
			k++;
		end
	endtask

	// High phase of the processor clock, in system cycles
	task hi_len(output int k);
		wait_for(mclk, 1'b0, k);
		wait_for(mclk, 1'b1, k);
		wait_for(mclk, 1'b0, k);
	endtask

	task sta_rd(input logic [1:0] s);
		hcrw_host_inst.acc(1'b1);
		hcrw_host_inst.rd(s);
		hcrw_host_inst.acc(1'b0);
		@(negedge sys_clk);
	endtask

	task close_out();
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Hang guard, far beyond the expected run of about 1300 cycles
	initial begin
		#100000;
		n_fail++;
		close_out();
	end

	initial begin
		{rst_n, osc_tick, upper_supply_threshold, lower_supply_threshold} = 4'h0;
		{osc_stable, irq_event, clock_power_up_request, line_activation_req, ci_in_valid, ci_in} = 9'h0;
		{upstream_line, line_deactivated} = 2'h3;
		repeat (8) @(posedge sys_clk);
		@(negedge sys_clk);
		chk(12'(prescale_select), 12'h1, "pre rst");
		chk(12'({reset_pin_o, reset_pin_oe, reset_n_out, mclk}), 12'hc, "rst pins");
		@(posedge sys_clk) rst_n <= 1'b1;
		repeat (20) @(negedge sys_clk);
		chk(12'(reset_pin_o), 12'h1, "held");
		@(posedge sys_clk) {upper_supply_threshold, osc_stable} <= 2'h3;
		wait_for(xcvr_reset, 1'b1, n);
		chk_n(n, 1, 12, "xcvr rst");
		repeat (3) @(negedge sys_clk);
		chk(12'(bp_clk_run), 12'h1, "bp on");
		wait_for(reset_pin_o, 1'b0, t);
		chk_n(n + t + 3, 60, 84, "por delay");
		chk(12'({reset_pin_oe, reset_n_out, bp_clk_run}), 12'h6, "released");
		repeat (150) @(negedge sys_clk);
		chk(12'(reset_pin_o), 12'h0, "no wd");
		@(posedge sys_clk) upstream_line <= 1'b0;
		repeat (6) @(negedge sys_clk);
		chk(12'(bp_clk_run), 12'h1, "du low");
		@(posedge sys_clk) {upstream_line, clock_power_up_request} <= 2'h3;
		repeat (6) @(negedge sys_clk);
		chk(12'(bp_clk_run), 12'h1, "pu bit");
		@(posedge sys_clk) {clock_power_up_request, line_activation_req} <= 2'h1;
		repeat (2) @(negedge sys_clk);
		chk(12'(bp_clk_run), 12'h1, "act req");
		$display("test power-up done");
		prev = 2'h1;
		for (int i = 0; i < 4; i++) begin
			hcrw_host_inst.acc(1'b1);
			hcrw_host_inst.wr_ctrl({codes[i], 3'h5, 6'h2a, 1'b1});
			@(negedge sys_clk);
			chk(12'(prescale_select), 12'(codes[i]), "pre reg");
			repeat (60) @(negedge sys_clk);
			hi_len(n);
			chk_n(n, 2 << prev, 2 << prev, "rate held");
			hcrw_host_inst.acc(1'b0);
			repeat (60) @(negedge sys_clk);
			hi_len(n);
			chk_n(n, 2 << codes[i], 2 << codes[i], "rate");
			prev = codes[i];
		end
		chk(12'({strobe_select, pulse_width_field, ring_contrast_select}), 12'h2d5, "ctrl");
		$display("test prescaler done");
		sta_rd(2'h2);
		chk(12'(ci_change_flag), 12'h1, "cic set");
		sta_rd(2'h1);
		chk(12'({ci_change_flag, int_n_oe}), 12'h0, "cleared");
		@(posedge sys_clk) irq_event <= 1'b1;
		@(posedge sys_clk) irq_event <= 1'b0;
		repeat (3) @(negedge sys_clk);
		chk(12'({int_n_oe, int_n_o}), 12'h2, "int on");
		hcrw_host_inst.acc(1'b1);
		@(negedge sys_clk);
		chk(12'(int_n_oe), 12'h0, "int mask");
		hcrw_host_inst.acc(1'b0);
		@(negedge sys_clk);
		chk(12'(int_n_oe), 12'h1, "int again");
		sta_rd(2'h2);
		chk(12'(int_n_oe), 12'h0, "int clr");
		$display("test interrupt done");
		hcrw_host_inst.wr_ctrl({2'h3, 3'h5, 6'h2a, 1'b1});
		hcrw_host_inst.wr_wd(2'h2);
		repeat (3) begin
			repeat (30) @(negedge sys_clk);
			hcrw_host_inst.wd_service();
		end
		chk(12'(reset_pin_o), 12'h0, "wd fed");
		wait_for(reset_pin_o, 1'b1, n);
		chk_n(n, 50, 80, "wd time");
		wait_for(reset_pin_o, 1'b0, t);
		chk_n(t, 56, 72, "wd width");
		chk(12'({prescale_select, strobe_select, pulse_width_field, ring_contrast_select}),
			12'h400, "wd clr");
		$display("test watchdog done");
		@(posedge sys_clk) {line_activation_req, ci_in_valid, ci_in} <= 6'h1a;
		@(posedge sys_clk) ci_in_valid <= 1'b0;
		repeat (4) @(negedge sys_clk);
		chk(12'({ci_change_flag, status_ci}), 12'h00f, "ci held");
		@(posedge sys_clk) line_activation_req <= 1'b1;
		repeat (3) @(negedge sys_clk);
		chk(12'({ci_change_flag, status_ci}), 12'h01a, "ci copied");
		$display("test indication done");
		@(posedge sys_clk) lower_supply_threshold <= 1'b1;
		repeat (7) @(negedge sys_clk);
		chk(12'(reset_pin_o), 12'h1, "uv rst");
		chk(12'(mclk), 12'h0, "uv mclk");
		$display("test undervoltage done");
		close_out();
	end
endmodule
